// ### common/rpor_pkg.sv
// Package: constants and types for the preload/observe/reset test block
package rpor_pkg;
	localparam int NUM_CELLS = 32;

	// Power-up reset time, ns, and derived longest cycle count at 25 MHz
	localparam int CLK_PERIOD_NS = 40;
	localparam int PUR_TIME_NS   = 10000;
	localparam int PUR_CYCLES    = PUR_TIME_NS / CLK_PERIOD_NS;
	localparam int PUR_CW        = 9;

	// Register byte addresses
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_CFG_REG  = 8'h04;
	localparam logic [7:0] ADDR_CFG_INV  = 8'h08;
	localparam logic [7:0] ADDR_CFG_OE   = 8'h0C;
	localparam logic [7:0] ADDR_CFG_BUR  = 8'h10;
	localparam logic [7:0] ADDR_LOGIC_D  = 8'h14;
	localparam logic [7:0] ADDR_RSTCTL   = 8'h18;
	localparam logic [7:0] ADDR_CELLS    = 8'h1C;
	localparam logic [7:0] ADDR_STATUS   = 8'h20;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

	typedef enum logic [1:0] {
		RPOR_MODE_NORMAL  = 2'h0,
		RPOR_MODE_PRELOAD = 2'h1,
		RPOR_MODE_OBSERVE = 2'h2
	} rpor_mode_t;

	// Status field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_MODE_LSB = 1;

	typedef struct packed {
		logic        sel;
		logic        write;
		logic [7:0]  addr;
	} rpor_ahb_req_t;
endpackage

// ### logic/rpor_core.sv
// Preload, observe and power-up reset logic for a bank of macrocell flip-flops
//
// Notes on behaviour
// - Power-up reset finishes within ten microseconds.
// - All flip-flops read low after reset.
// - Pin level is cleared value through polarity.
// - Preload loads each flip-flop from pin.
// - Observe overrides output enable, drives buffer.
// - Observe shows output and buried registers.
// - Combinatorial outputs forced registered during test.
// - Product terms forced zero while forced.
// - Combinatorial output recovers after test ends.
// - Asserted async reset overwrites preload.
`timescale 1ns/1ps

module rpor_core #(
	parameter int N          = rpor_pkg::NUM_CELLS,
	parameter int PUR_CYCLES = rpor_pkg::PUR_CYCLES
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic      [31:0]  hrdata,
	output logic              hreadyout,
	output logic              hresp,
	input  wire logic [N-1:0] pin_in,
	output logic      [N-1:0] pin_out,
	output logic      [N-1:0] pin_oe_n,
	output logic              test_active
);
	localparam logic [rpor_pkg::PUR_CW-1:0] PUR_LAST = (rpor_pkg::PUR_CW)'(PUR_CYCLES - 1);

	// Bus request registered at address phase
	rpor_pkg::rpor_ahb_req_t req_q;
	logic [31:0] rdata_q;

	// Configuration and control
	rpor_pkg::rpor_mode_t mode_q;
	logic [N-1:0] cfg_reg_q;    // 1 = registered macrocell
	logic [N-1:0] cfg_inv_q;    // 1 = output inverted
	logic [N-1:0] cfg_oe_q;     // programmed output enable
	logic [N-1:0] cfg_bur_q;    // 1 = buried cell
	logic [N-1:0] logic_d_q;    // product-term sum per cell
	logic [N-1:0] rst_ctl_q;    // async reset line per cell
	logic [N-1:0] cell_q;       // macrocell flip-flops
	logic [N-1:0] pin_s1_q;
	logic [N-1:0] pin_s2_q;
	logic [N-1:0] pin_out_q;
	logic [N-1:0] pin_oe_n_q;
	logic [rpor_pkg::PUR_CW-1:0] pur_cnt_q;
	logic         pur_busy_q;
	logic         test_q;

	wire logic in_test = (mode_q != rpor_pkg::RPOR_MODE_NORMAL);
	wire logic wr_now  = req_q.sel && req_q.write;

	// Address phase capture; single-cycle answer, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
		end else if (hready) begin
			req_q.sel   <= hsel && (htrans == rpor_pkg::HTRANS_NONSEQ)
				&& (hsize == rpor_pkg::HSIZE_WORD);
			req_q.write <= hwrite;
			req_q.addr  <= haddr[7:0];
		end else begin
			req_q.sel <= 1'b0;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Power-up reset sequencer; counter bounded by the longest time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pur_cnt_q  <= '0;
			pur_busy_q <= 1'b1;
		end else if (pur_busy_q) begin
			if (pur_cnt_q == PUR_LAST) begin
				pur_busy_q <= 1'b0;
			end else begin
				pur_cnt_q <= pur_cnt_q + 1'b1;
			end
		end
	end

	// Pin inputs are asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Mode register; writes ignored during power-up reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= rpor_pkg::RPOR_MODE_NORMAL;
		end else if (wr_now && !pur_busy_q && req_q.addr == rpor_pkg::ADDR_MODE) begin
			case (hwdata[1:0])
				rpor_pkg::RPOR_MODE_PRELOAD: mode_q <= rpor_pkg::RPOR_MODE_PRELOAD;
				rpor_pkg::RPOR_MODE_OBSERVE: mode_q <= rpor_pkg::RPOR_MODE_OBSERVE;
				default:                     mode_q <= rpor_pkg::RPOR_MODE_NORMAL;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg_q <= '0;
			cfg_inv_q <= '0;
			cfg_oe_q  <= '0;
			cfg_bur_q <= '0;
			logic_d_q <= '0;
			rst_ctl_q <= '0;
		end else if (wr_now) begin
			case (req_q.addr)
				rpor_pkg::ADDR_CFG_REG: cfg_reg_q <= hwdata[N-1:0];
				rpor_pkg::ADDR_CFG_INV: cfg_inv_q <= hwdata[N-1:0];
				rpor_pkg::ADDR_CFG_OE:  cfg_oe_q  <= hwdata[N-1:0];
				rpor_pkg::ADDR_CFG_BUR: cfg_bur_q <= hwdata[N-1:0];
				rpor_pkg::ADDR_LOGIC_D: logic_d_q <= hwdata[N-1:0];
				rpor_pkg::ADDR_RSTCTL:  rst_ctl_q <= hwdata[N-1:0];
				default: ;
			endcase
		end
	end

	// Product terms are masked to zero while any test mode is active
	wire logic [N-1:0] pterm = in_test ? '0 : logic_d_q;

	// Per-cell flip-flop and pin driver
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cell
			// Async reset line beats preload, so a preloaded state that
			// asserts it is lost; the tester must avoid such states.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cell_q[g] <= 1'b0;
				end else if (pur_busy_q) begin
					cell_q[g] <= 1'b0;
				end else if (rst_ctl_q[g]) begin
					cell_q[g] <= 1'b0;
				end else if (mode_q == rpor_pkg::RPOR_MODE_PRELOAD) begin
					cell_q[g] <= pin_s2_q[g];
				end else if (mode_q == rpor_pkg::RPOR_MODE_NORMAL) begin
					cell_q[g] <= pterm[g];
				end
			end

			// Combinatorial cells use the registered value while in test
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_out_q[g]  <= 1'b0;
					pin_oe_n_q[g] <= 1'b1;
				end else if (pur_busy_q) begin
					pin_out_q[g]  <= cfg_inv_q[g];
					pin_oe_n_q[g] <= ~cfg_oe_q[g];
				end else if (mode_q == rpor_pkg::RPOR_MODE_OBSERVE) begin
					pin_out_q[g]  <= cell_q[g] ^ cfg_inv_q[g];
					pin_oe_n_q[g] <= 1'b0;
				end else if (mode_q == rpor_pkg::RPOR_MODE_PRELOAD) begin
					pin_out_q[g]  <= cell_q[g] ^ cfg_inv_q[g];
					pin_oe_n_q[g] <= 1'b1;
				end else begin
					pin_out_q[g]  <= (cfg_reg_q[g] ? cell_q[g] : logic_d_q[g])
						^ cfg_inv_q[g];
					pin_oe_n_q[g] <= ~(cfg_oe_q[g] & ~cfg_bur_q[g]);
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_q <= 1'b0;
		end else begin
			test_q <= in_test;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_q = rpor_pkg::ZERO_WORD;
		case (req_q.addr)
			rpor_pkg::ADDR_MODE:    rdata_q[1:0]   = mode_q;
			rpor_pkg::ADDR_CFG_REG: rdata_q[N-1:0] = cfg_reg_q;
			rpor_pkg::ADDR_CFG_INV: rdata_q[N-1:0] = cfg_inv_q;
			rpor_pkg::ADDR_CFG_OE:  rdata_q[N-1:0] = cfg_oe_q;
			rpor_pkg::ADDR_CFG_BUR: rdata_q[N-1:0] = cfg_bur_q;
			rpor_pkg::ADDR_LOGIC_D: rdata_q[N-1:0] = logic_d_q;
			rpor_pkg::ADDR_RSTCTL:  rdata_q[N-1:0] = rst_ctl_q;
			rpor_pkg::ADDR_CELLS:   rdata_q[N-1:0] = cell_q;
			rpor_pkg::ADDR_STATUS: begin
				rdata_q[rpor_pkg::ST_BUSY_BIT]                  = pur_busy_q;
				rdata_q[rpor_pkg::ST_MODE_LSB+1:rpor_pkg::ST_MODE_LSB] = mode_q;
			end
			default: ;
		endcase
	end

	assign hrdata      = rdata_q;
	assign pin_out     = pin_out_q;
	assign pin_oe_n    = pin_oe_n_q;
	assign test_active = test_q;

	// Power-up reset ends within the bounded count after release
	chk_pur_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(hresetn) |-> ##[0:250] !pur_busy_q)
		else $error("power-up reset too long");

	chk_pur_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(pur_busy_q) |-> cell_q == '0)
		else $error("cells not low after power-up reset");

	chk_pur_polar: assert property (@(posedge hclk) disable iff (!hresetn)
		pur_busy_q |=> (pin_out_q == $past(cfg_inv_q)))
		else $error("pin level not inverted cleared value");

	chk_preload_load: assert property (@(posedge hclk) disable iff (!hresetn)
		(!pur_busy_q && mode_q == rpor_pkg::RPOR_MODE_PRELOAD)
		|=> (cell_q & ~$past(rst_ctl_q)) == ($past(pin_s2_q) & ~$past(rst_ctl_q)))
		else $error("preload did not load pins");

	chk_observe_oe: assert property (@(posedge hclk) disable iff (!hresetn)
		(!pur_busy_q && mode_q == rpor_pkg::RPOR_MODE_OBSERVE) |=> pin_oe_n_q == '0)
		else $error("observe did not enable all drivers");

	chk_observe_val: assert property (@(posedge hclk) disable iff (!hresetn)
		(!pur_busy_q && mode_q == rpor_pkg::RPOR_MODE_OBSERVE)
		|=> pin_out_q == ($past(cell_q) ^ $past(cfg_inv_q)))
		else $error("observe value mismatch");

	chk_pterm_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		in_test |-> pterm == '0)
		else $error("product terms not forced zero");

	chk_comb_return: assert property (@(posedge hclk) disable iff (!hresetn)
		(!pur_busy_q && !in_test && cfg_reg_q == '0)
		|=> pin_out_q == ($past(logic_d_q) ^ $past(cfg_inv_q)))
		else $error("combinatorial output wrong in normal mode");

	chk_async_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		(rst_ctl_q != '0) |=> (cell_q & $past(rst_ctl_q)) == '0)
		else $error("async reset did not clear cell");

	chk_mode_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!wr_now |=> $stable(mode_q))
		else $error("mode changed without write");
endmodule

// ### testbench/rpor_tester.sv
// Tester model at the pins: presents, releases and reads the pad levels
`timescale 1ns/1ps
module rpor_tester (
	input  wire logic        hclk,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe_n,
	input  wire logic        drv_en,
	input  wire logic [31:0] drv_val,
	output logic      [31:0] pin_lvl
);
	logic [31:0] last_q = 32'h0000_0000;
	// Released pads have no pull, so show a toggling value, never a held one
	always @(posedge hclk) last_q <= pin_lvl;
	// Device drive wins the pad; tester data only where the device is off
	assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & (drv_en ? drv_val : ~last_q));
endmodule

// ### testbench/register_preload_observe_reset_tb_top.sv
// Self-checking bench for the preload, observe and power-up reset block
`timescale 1ns/1ps
module register_preload_observe_reset_tb_top;
	localparam int PC = 40;
	typedef struct {logic [31:0] e; bit c; logic [7:0] n;} rpor_note_t;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, den = 0, rd_ph = 0, smp = 0;
	logic [31:0] haddr = 0, hwdata = 0, dval = 0, hrdata, pin_in, pin_out, pin_oe_n;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 0;
	logic        hreadyout, hresp, test_active;
	logic [31:0] rnd = 32'h076ADC77, rdv, v, m, ld;
	int          mismatches = 0, checked = 0, cyc = 0;
	rpor_note_t  nq[$];
	rpor_note_t  nt;

	always #20 hclk = ~hclk;

	rpor_core #(.N(32), .PUR_CYCLES(PC)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .test_active(test_active));
	rpor_tester u_tst (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv_en(den),
		.drv_val(dval), .pin_lvl(pin_in));

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
	endfunction

	task automatic test_done;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [31:0] e, input bit c);
		@(posedge hclk);
		hsel <= 1;
		haddr <= {24'h00_0000, a};
		htrans <= rpor_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= rpor_pkg::HSIZE_WORD;
		if (!w)
			nq.push_back('{e, c, a});
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, 32'h0000_0000, 0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0000_0000, e, 1);
	endtask

	// Code FF samples the pad levels, FE the test mode flag
	task automatic note(input logic [31:0] e, input logic [7:0] n);
		@(posedge hclk);
		nq.push_back('{e, 1, n});
		smp <= 1;
		@(posedge hclk);
		smp <= 0;
	endtask

	always @(posedge hclk) begin
		if (rd_ph || smp) begin
			nt = nq.pop_front();
			checked += nt.c;
			if (nt.c && (rd_ph ? hrdata : nt.n == 8'hFE ? {31'h0, test_active} : pin_in) !== nt.e) begin
				mismatches++;
				$display("BAD %h exp %h got %h h %h p %h", nt.n, nt.e, rd_ph, hrdata, pin_in);
			end
		end
		if (rd_ph && hresp !== 1'b0) begin
			mismatches++;
			$display("BAD hresp exp 0 got %b", hresp);
		end
		rd_ph <= hsel && htrans == rpor_pkg::HTRANS_NONSEQ && !hwrite && hreadyout;
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			test_done;
		end
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		rd(rpor_pkg::ADDR_STATUS, 32'h0000_0001);
		rd(rpor_pkg::ADDR_CELLS, 32'h0000_0000);
		wr(rpor_pkg::ADDR_MODE, 32'h0000_0001);
		rnd = lfsr(rnd);
		wr(rpor_pkg::ADDR_CFG_OE, 32'hFFFF_FFFF);
		wr(rpor_pkg::ADDR_CFG_INV, rnd);
		note(rnd, 8'hFF);
		rd(rpor_pkg::ADDR_STATUS, 32'h0000_0001);
		// Tester holds off clocked work until the reset window is over
		repeat (PC) @(posedge hclk);
		rd(rpor_pkg::ADDR_STATUS, 32'h0000_0000);
		$display("test power_up done");
		for (int i = 0; i < 3; i++) begin
			wr(rpor_pkg::ADDR_MODE, i);
			rd(rpor_pkg::ADDR_STATUS, {29'h0, i[1:0], 1'b0});
			note({31'h0, i != 0}, 8'hFE);
		end
		$display("test modes done");
		wr(rpor_pkg::ADDR_MODE, 32'h0000_0000);
		wr(rpor_pkg::ADDR_CFG_INV, 32'h0000_0000);
		wr(rpor_pkg::ADDR_CFG_REG, 32'h0000_0000);
		wr(rpor_pkg::ADDR_CFG_OE, 32'h0000_0000);
		rnd = lfsr(rnd);
		wr(rpor_pkg::ADDR_CFG_BUR, rnd);
		rnd = lfsr(rnd);
		ld = rnd;
		wr(rpor_pkg::ADDR_LOGIC_D, ld);
		rnd = lfsr(rnd);
		m = rnd & 32'h0000_0F0F;
		// Reset lines set on purpose here to see them win over preload
		wr(rpor_pkg::ADDR_RSTCTL, m);
		wr(rpor_pkg::ADDR_MODE, 32'h0000_0001);
		rnd = lfsr(rnd);
		v = rnd;
		dval <= v;
		den <= 1;
		repeat (5) @(posedge hclk);
		rd(rpor_pkg::ADDR_CELLS, v & ~m);
		wr(rpor_pkg::ADDR_MODE, 32'h0000_0002);
		den <= 0;
		note(v & ~m, 8'hFF);
		$display("test preload_observe done");
		wr(rpor_pkg::ADDR_MODE, 32'h0000_0000);
		wr(rpor_pkg::ADDR_CFG_OE, 32'hFFFF_FFFF);
		wr(rpor_pkg::ADDR_CFG_BUR, 32'h0000_0000);
		rnd = lfsr(rnd);
		wr(rpor_pkg::ADDR_CFG_INV, rnd);
		note(ld ^ rnd, 8'hFF);
		rd(rpor_pkg::ADDR_CELLS, ld & ~m);
		wr(8'h24, rnd);
		rd(8'h24, 32'h0000_0000);
		$display("test restore done");
		hresetn <= 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		rd(rpor_pkg::ADDR_CELLS, 32'h0000_0000);
		rd(rpor_pkg::ADDR_STATUS, 32'h0000_0001);
		$display("test second_reset done");
		test_done;
	end
endmodule
